// file: common/pmx_pkg.sv
// Types for the capability option block
package pmx_pkg;
  typedef enum logic [1:0] {
    PMX_MSIX_EXTERNAL,
    PMX_MSIX_INTERNAL,
    PMX_MSIX_STREAM,
    PMX_MSIX_NONE
  } pmx_msix_mode_e;
  typedef enum logic [1:0] {
    PMX_EXT_NONE,
    PMX_EXT_SMALL,
    PMX_EXT_LARGE
  } pmx_ext_mode_e;
  typedef enum logic [1:0] {
    PMX_SPEED_2G5,
    PMX_SPEED_5G0,
    PMX_SPEED_8G0,
    PMX_SPEED_16G0
  } pmx_speed_e;
  typedef enum logic [1:0] {
    PMX_ROUTE_IDLE,
    PMX_ROUTE_CORE,
    PMX_ROUTE_APP,
    PMX_ROUTE_ZERO
  } pmx_route_e;
endpackage : pmx_pkg

// file: common/pmx_regs.svh
// Offsets, field widths and capability IDs for the capability option block
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH
`define PMX_EXT_SMALL_LO 12'he00
`define PMX_EXT_LARGE_LO 12'h600
`define PMX_EXT_HI 12'hfff
`define PMX_CAP_ID_MSIX 8'h11
`define PMX_CAP_ID_MSI 8'h05
`define PMX_BIR_W 3
`define PMX_TSIZE_W 11
`define PMX_BAR_COUNT 6
`define PMX_NO_BAR 3'h7
`endif

// file: hdl/pmx_cfg_options.sv
// MSI-X capability encoding and extended configuration routing
// What this block does
// - Internal option: core holds table and array; application drives requests.
// - Option none: no MSI-X capability and no MSI-X interrupts.
// - Table size field holds vector count minus one.
// - Table sits at offset in chosen BAR; 64-bit BAR named by lower dword.
// - Pending array sits at offset in its chosen memory BAR.
// - Capability shown only when enabled and a memory BAR exists.
// - Small option routes offsets 0xe00 to 0xfff to the application.
// - Large option routes offsets 0x600 to 0xfff to the application.
// - No extended option gives no application extended space.
// - L0s offered only at 2.5 or 5.0 Gb/s.
// - No TLP processing hints capability.
// - Same MSI-X options with or without SR-IOV.
// - MSI-X structure present per function only if enabled for it.
// - No MSI capability with internal MSI-X option.
`include "pmx_regs.svh"
module pmx_cfg_options
  import pmx_pkg::*;
#(
  parameter int unsigned MAX_VECTORS = 2048
)
(
  input wire logic clock,
  input wire logic rst,
  input wire pmx_msix_mode_e msix_mode,
  input wire logic sriov_enable,
  input wire logic msix_cap_enable,
  input wire logic msi_cap_enable,
  input wire logic [`PMX_BAR_COUNT-1:0] bar_enable,
  input wire logic [`PMX_BAR_COUNT-1:0] bar_is_memory,
  input wire logic [`PMX_BAR_COUNT-1:0] bar_is_64,
  input wire logic [11:0] msix_vectors,
  input wire logic [2:0] table_bar,
  input wire logic [28:0] table_offset,
  input wire logic [2:0] pba_bar,
  input wire logic [28:0] pba_offset,
  input wire pmx_ext_mode_e ext_mode,
  input wire pmx_speed_e link_speed,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [11:0] cfg_addr,
  input wire logic cfg_core_claim,
  input wire logic [31:0] cfg_core_rdata,
  input wire logic [31:0] app_rdata,
  input wire logic msix_int_req,
  output logic app_req,
  output logic app_write,
  output logic [11:0] app_addr,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  output logic msix_present,
  output logic msi_present,
  output logic tph_present,
  output logic msix_table_in_core,
  output logic msix_stream_path,
  output logic msix_int_fire,
  output logic [`PMX_TSIZE_W-1:0] table_size_field,
  output logic [31:0] table_dword,
  output logic [31:0] pba_dword,
  output logic l0s_supported
);
  // ************************************
  // Helpers
  // ************************************
  // Lower dword BAR of a 64-bit pair is the even one
  function automatic logic bar_ok(input logic [2:0] bir, input logic [`PMX_BAR_COUNT-1:0] en,
                                  input logic [`PMX_BAR_COUNT-1:0] mem);
    logic ok;
    ok = 1'b0;
    if (bir < 3'(`PMX_BAR_COUNT)) begin
      ok = en[bir] & mem[bir];
    end
    return ok;
  endfunction : bar_ok

  // ************************************
  // Option decode state
  // ************************************
  logic msix_present_next;
  logic msi_present_next;
  logic core_table_next;
  logic stream_next;
  logic l0s_next;
  logic fire_next;
  logic [`PMX_TSIZE_W-1:0] tsize_next;
  logic [31:0] table_next;
  logic [31:0] pba_next;
  logic [2:0] table_bir;
  logic any_mem_bar;
  logic in_window;

  always_comb begin
    any_mem_bar = |(bar_enable & bar_is_memory);
    table_bir = table_bar;
    if (table_bar != 3'h0 && table_bar < 3'(`PMX_BAR_COUNT) && !table_bar[0] == 1'b0 &&
        bar_is_64[table_bar - 3'h1] && !bar_enable[table_bar]) begin
      table_bir = table_bar - 3'h1;
    end
    // gate on option, enable and a memory BAR
    msix_present_next = (msix_mode != PMX_MSIX_NONE) && msix_cap_enable && any_mem_bar &&
                        bar_ok(table_bir, bar_enable, bar_is_memory) &&
                        bar_ok(pba_bar, bar_enable, bar_is_memory);
    // MSI withheld when internal option shares its signals
    msi_present_next = msi_cap_enable && (msix_mode != PMX_MSIX_INTERNAL);
    core_table_next = msix_present_next && (msix_mode == PMX_MSIX_INTERNAL);
    stream_next = msix_present_next && (msix_mode == PMX_MSIX_STREAM);
    // requests only for external or internal options
    fire_next = msix_int_req && msix_present_next && !stream_next;
    // count minus one, clipped to range
    if (msix_vectors == 12'h000) begin
      tsize_next = '0;
    end else if (msix_vectors > 12'(MAX_VECTORS)) begin
      tsize_next = `PMX_TSIZE_W'(MAX_VECTORS - 1);
    end else begin
      tsize_next = `PMX_TSIZE_W'(msix_vectors - 12'h001);
    end
    table_next = {table_offset, table_bir};
    // pending array offset and BIR dword
    pba_next = {pba_offset, pba_bar};
    if (!msix_present_next) begin
      tsize_next = '0;
      table_next = '0;
      pba_next = '0;
    end
    // L0s only at the two lower speeds
    l0s_next = (link_speed == PMX_SPEED_2G5) || (link_speed == PMX_SPEED_5G0);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      msix_present <= 1'b0;
      msi_present <= 1'b0;
      msix_table_in_core <= 1'b0;
      msix_stream_path <= 1'b0;
      msix_int_fire <= 1'b0;
      table_size_field <= '0;
      table_dword <= '0;
      pba_dword <= '0;
      l0s_supported <= 1'b0;
    end else begin
      msix_present <= msix_present_next;
      msi_present <= msi_present_next;
      msix_table_in_core <= core_table_next;
      msix_stream_path <= stream_next;
      msix_int_fire <= fire_next;
      table_size_field <= tsize_next;
      table_dword <= table_next;
      pba_dword <= pba_next;
      l0s_supported <= l0s_next;
    end
  end

  assign tph_present = 1'b0;

  // ************************************
  // Config access routing
  // ************************************
  pmx_ext_window u_window (
    .addr(cfg_addr),
    .ext_mode(ext_mode),
    .in_window(in_window)
  );

  pmx_route_e route_reg;
  pmx_route_e route_next;
  logic [31:0] rdata_next;
  logic app_req_next;
  logic [11:0] app_addr_next;
  logic app_write_next;

  always_comb begin
    route_next = PMX_ROUTE_IDLE;
    app_req_next = 1'b0;
    app_write_next = 1'b0;
    app_addr_next = app_addr;
    rdata_next = 32'h0000_0000;
    if (cfg_req) begin
      // Core capabilities take priority over the app window
      if (cfg_core_claim) begin
        route_next = PMX_ROUTE_CORE;
        rdata_next = cfg_write ? 32'h0000_0000 : cfg_core_rdata;
      end else if (in_window) begin
        route_next = PMX_ROUTE_APP;
        app_req_next = 1'b1;
        app_write_next = cfg_write;
        app_addr_next = cfg_addr;
      end else begin
        route_next = PMX_ROUTE_ZERO;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      route_reg <= PMX_ROUTE_IDLE;
      app_req <= 1'b0;
      app_write <= 1'b0;
      app_addr <= 12'h000;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      route_reg <= route_next;
      app_req <= app_req_next;
      app_write <= app_write_next;
      app_addr <= app_addr_next;
      cfg_rdata <= rdata_next;
    end
  end

  // Ack one cycle after the take, decoded from the registered route
  always_comb begin
    case (route_reg)
      PMX_ROUTE_CORE: cfg_ack = 1'b1;
      PMX_ROUTE_APP: cfg_ack = 1'b1;
      PMX_ROUTE_ZERO: cfg_ack = 1'b1;
      default: cfg_ack = 1'b0;
    endcase
  end
endmodule : pmx_cfg_options

// file: hdl/pmx_ext_window.sv
// Extended configuration window decoder
`include "pmx_regs.svh"
module pmx_ext_window
  import pmx_pkg::*;
(
  input wire logic [11:0] addr,
  input wire pmx_ext_mode_e ext_mode,
  output logic in_window
);
  // ************************************
  // Window decode
  // ************************************
  always_comb begin
    case (ext_mode)
      PMX_EXT_SMALL: in_window = (addr >= `PMX_EXT_SMALL_LO) && (addr <= `PMX_EXT_HI);
      PMX_EXT_LARGE: in_window = (addr >= `PMX_EXT_LARGE_LO) && (addr <= `PMX_EXT_HI);
      default: in_window = 1'b0;
    endcase
  end
endmodule : pmx_ext_window

// file: verif/pmx_app_model.sv
// Application side model of the extended configuration space
module pmx_app_model (
  input wire logic clock,
  input wire logic app_req,
  input wire logic [11:0] app_addr,
  output logic [31:0] app_rdata = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock) begin
    // Idle bus toggles so stale data never looks valid
    app_rdata <= app_req ? {20'h0a5a5, app_addr} : ~app_rdata;
  end
endmodule : pmx_app_model

// file: verif/pmx_cfg_options_asserts.sv
// Port assertions for the capability option block
module pmx_cfg_options_asserts
  import pmx_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire pmx_msix_mode_e msix_mode,
  input wire pmx_ext_mode_e ext_mode,
  input wire pmx_speed_e link_speed,
  input wire logic cfg_req,
  input wire logic [11:0] cfg_addr,
  input wire logic cfg_core_claim,
  input wire logic msix_int_req,
  input wire logic app_req,
  input wire logic [11:0] app_addr,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic msix_present,
  input wire logic msi_present,
  input wire logic tph_present,
  input wire logic msix_int_fire,
  input wire logic l0s_supported
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_take(pmx_ext_mode_e m, logic [11:0] lo);
    cfg_req && !cfg_core_claim && ext_mode == m && cfg_addr >= lo;
  endsequence
  sequence s_fwd(logic [11:0] a);
    cfg_ack && app_req && app_addr == a;
  endsequence
  a_small_route: assert property (s_take(PMX_EXT_SMALL, 12'he00) |=> s_fwd($past(cfg_addr)))
    else $error("small window not forwarded");
  a_large_route: assert property (s_take(PMX_EXT_LARGE, 12'h600) |=> s_fwd($past(cfg_addr)))
    else $error("large window not forwarded");
  a_none_noapp: assert property (s_take(PMX_EXT_NONE, 12'h000) |=> cfg_ack && !app_req && cfg_rdata == 32'h0)
    else $error("app space without window");
  a_tph_absent: assert property (!tph_present)
    else $error("tph shown");
  a_msi_internal: assert property (msix_mode == PMX_MSIX_INTERNAL |=> !msi_present)
    else $error("msi with internal table");
  a_none_absent: assert property (msix_mode == PMX_MSIX_NONE |=> !msix_present && !msix_int_fire)
    else $error("msix with option none");
  a_l0s_speed: assert property (l0s_supported |-> $past(link_speed) < PMX_SPEED_8G0)
    else $error("l0s at high speed");
  a_stream_fire: assert property (msix_int_fire |-> $past(msix_int_req) && $past(msix_mode) != PMX_MSIX_STREAM)
    else $error("fire without cause");
endmodule : pmx_cfg_options_asserts
bind pmx_cfg_options pmx_cfg_options_asserts chk_u (.*);

// file: verif/pmx_cfg_options_tb.sv
// Self-checking bench for the capability option block
module pmx_cfg_options_tb import pmx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAXV = 100;
  localparam logic [11:0] CADDR [8] = '{12'hfff, 12'he00, 12'h600, 12'h000, 12'hdff, 12'h5ff, 12'he00, 12'hfff};
  localparam logic [11:0] CVEC [8] = '{12'h010, 12'h001, 12'h000, 12'h064, 12'h065, 12'h800, 12'hfff, 12'h010};
  logic clock = 0, rst = 1, sriov_enable = 0, msix_cap_enable = 0, msi_cap_enable = 0;
  logic cfg_req = 0, cfg_write = 0, cfg_core_claim = 0, msix_int_req = 0;
  logic app_req, app_write, cfg_ack, msix_present, msi_present, tph_present;
  logic msix_table_in_core, msix_stream_path, msix_int_fire, l0s_supported;
  pmx_msix_mode_e msix_mode = PMX_MSIX_NONE;
  pmx_ext_mode_e ext_mode = PMX_EXT_NONE;
  pmx_speed_e link_speed = PMX_SPEED_2G5;
  logic [5:0] bar_enable = 0, bar_is_memory = 0, bar_is_64 = 0;
  logic [11:0] msix_vectors = 0, cfg_addr = 0, app_addr;
  logic [2:0] table_bar = 0, pba_bar = 0;
  logic [28:0] table_offset = 0, pba_offset = 0;
  logic [31:0] cfg_core_rdata = 0, app_rdata, cfg_rdata, table_dword, pba_dword;
  logic [10:0] table_size_field;
  int error_cnt = 0, check_count = 0, seed = 6301;
  pmx_cfg_options #(.MAX_VECTORS(MAXV)) dut_u (.*);
  pmx_app_model app_u (.*);
  // ****
  // Helpers
  // ****
  task automatic chk(string nm, logic [79:0] seen, logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  function automatic logic bar_ok(logic [2:0] b);
    return b < 3'h6 && bar_enable[b] && bar_is_memory[b];
  endfunction : bar_ok
  task automatic check_all();
    logic p, w;
    logic [2:0] tbir;
    logic [10:0] sz;
    // upper half of a 64-bit pair names its lower BAR
    tbir = table_bar;
    if (table_bar[0] && table_bar < 3'h6 && bar_is_64[table_bar - 3'h1] && !bar_enable[table_bar]) begin
      tbir = table_bar - 3'h1;
    end
    p = msix_mode != PMX_MSIX_NONE && msix_cap_enable && bar_ok(tbir) && bar_ok(pba_bar);
    sz = msix_vectors == 0 ? 11'h0 : msix_vectors > MAXV ? 11'(MAXV - 1) : 11'(msix_vectors - 1);
    w = ext_mode == PMX_EXT_SMALL ? cfg_addr >= 12'he00 : ext_mode == PMX_EXT_LARGE && cfg_addr >= 12'h600;
    w = w && cfg_req && !cfg_core_claim;
    chk("msix", {msix_present, msix_table_in_core, msix_stream_path, table_size_field},
      {p, p && msix_mode == PMX_MSIX_INTERNAL, p && msix_mode == PMX_MSIX_STREAM, p ? sz : 11'h0});
    chk("bars", {table_dword, pba_dword}, p ? {table_offset, tbir, pba_offset, pba_bar} : 64'h0);
    chk("caps", {msi_present, tph_present, l0s_supported, msix_int_fire},
      {msi_cap_enable && msix_mode != PMX_MSIX_INTERNAL, 1'h0, link_speed < PMX_SPEED_8G0,
      msix_int_req && p && msix_mode != PMX_MSIX_STREAM});
    chk("cfg", {cfg_ack, app_req, cfg_rdata},
      {cfg_req, w, (cfg_req && cfg_core_claim && !cfg_write) ? cfg_core_rdata : 32'h0});
    if (w) chk("app", {app_addr, app_write}, {cfg_addr, cfg_write});
  endtask : check_all
  // ****
  // Sequence
  // ****
  initial forever #5 clock = ~clock;
  initial begin
    #50us;
    error_cnt++;
    finish_test();
  end
  initial begin
    logic [31:0] r;
    logic c;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    #1 chk("rst", {msix_present, cfg_ack, app_req}, 3'h0);
    for (int i = 0; i < 400; i++) begin
      @(posedge clock);
      r = $random(seed);
      c = i < 8;
      {msix_cap_enable, msi_cap_enable, sriov_enable, cfg_req, cfg_write, cfg_core_claim, msix_int_req} <=
        r[6:0] & {6'h3f, !c} | {c, 2'h0, c, 3'h0};
      msix_mode <= pmx_msix_mode_e'(i[1:0]);
      ext_mode <= pmx_ext_mode_e'(i % 3);
      link_speed <= pmx_speed_e'(i[3:2]);
      {bar_enable, bar_is_memory} <= c ? 12'hfff : r[18:7] | r[30:19];
      {bar_is_64, table_bar, pba_bar} <= c ? 12'h008 : 12'($random(seed));
      cfg_addr <= c ? CADDR[i % 8] : 12'($random(seed));
      msix_vectors <= c ? CVEC[i % 8] : 12'($random(seed));
      {table_offset, pba_offset} <= 58'({$random(seed), $random(seed)});
      cfg_core_rdata <= $random(seed);
      @(posedge clock);
      #1 check_all();
    end
    finish_test();
  end
endmodule : pmx_cfg_options_tb
